// file: rtl/sso_status_outputs.sv
// Purpose: Discrete status flags and output allocation of a servo drive
// Assumes: Motion quantities arrive on the control clock, 50 MHz
// Notes: Thresholds take effect on the edge after the write
//
// Function
// RQ1: Warning flag follows pre-alarm warning condition
// RQ2: Rotation flag above level, clear below
// RQ3: Rotation level 1..10000 rpm, default 20
// RQ4: Ready needs power, no base block, no alarm
// RQ5: Servo-on accepted only while ready
// RQ6: Host reads absolute data before encoder power-on
// RQ7: Coincidence when speed difference below width
// RQ8: Coincidence flag only in speed control
// RQ9: Coincidence width 0..100 rpm, default 10
// RQ10: Done when position error below width
// RQ11: Done width 0..1073741824, default 7
// RQ12: Done width never touches position loop
// RQ13: Timing 0 error only, 2 also zero reference
// RQ14: Timing 1 also needs filtered reference zero
// RQ15: Flags reach pins only through allocation digits
`timescale 1ns/1ps
`default_nettype none
module sso_status_outputs
	import sso_pkg::*;
#(
	parameter int NUM_OUT = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	// Power and safety pins
	input wire logic mainPowerPin,
	input wire logic baseBlockPin,
	// Drive state from control logic
	input wire logic warningActive,
	input wire logic alarmActive,
	input wire logic speedMode,
	input wire logic positionMode,
	// Motion quantities
	input wire logic signed [15:0] motorSpeed,
	input wire logic signed [15:0] refSpeed,
	input wire logic signed [31:0] positionError,
	input wire logic signed [31:0] positionRefInput,
	input wire logic signed [31:0] filteredPositionRef,
	// Host commands
	input wire logic encoder_power_on_cmd,
	input wire logic servo_on_cmd,
	input wire logic servoOffCmd,
	// Status flags
	output logic warningOut,
	output logic rotation_detected_out,
	output logic servoReadyOut,
	output logic speed_coincidence_out,
	output logic positioning_done_out,
	output logic servoOnOut,
	// Allocated physical outputs
	output logic [NUM_OUT-1:0] statusPinOut
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pinClean;
	logic mainPowerOn, hardwired_base_block;

	sso_pin_sync #(.WIDTH(2)) u_pin_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pinRaw({baseBlockPin, mainPowerPin}),
		.pinClean(pinClean)
	);
	assign mainPowerOn = pinClean[0];
	assign hardwired_base_block = pinClean[1];

	// ----------------------------------------------------------------
	// Setting registers
	// ----------------------------------------------------------------
	logic [13:0] rotation_detect_level_ff, nxt_rotation_detect_level;
	logic [6:0] speed_coincidence_width_ff, nxt_speed_coincidence_width;
	logic [30:0] positioning_done_width_ff, nxt_positioning_done_width;
	logic [1:0] done_output_timing_select_ff, nxt_done_output_timing_select;
	logic [15:0] output_allocation_a_ff, nxt_output_allocation_a;
	logic [15:0] output_allocation_b_ff, nxt_output_allocation_b;
	logic absEncoder_ff, nxt_absEncoder;
	logic [31:0] rdData_ff, nxt_rdData;
	logic [31:0] statusWord;

	// Writes in range update at once; out-of-range writes are dropped
	always_comb begin
		nxt_rotation_detect_level = rotation_detect_level_ff;
		nxt_speed_coincidence_width = speed_coincidence_width_ff;
		nxt_positioning_done_width = positioning_done_width_ff;
		nxt_done_output_timing_select = done_output_timing_select_ff;
		nxt_output_allocation_a = output_allocation_a_ff;
		nxt_output_allocation_b = output_allocation_b_ff;
		nxt_absEncoder = absEncoder_ff;
		if (regWrite) begin
			unique case (regAddr)
				SSO_OFS_ROT_LEVEL: begin
					if (regWrData >= SSO_ROT_LEVEL_MIN && regWrData <= SSO_ROT_LEVEL_MAX) begin
						nxt_rotation_detect_level = regWrData[13:0]; // RQ3
					end
				end
				SSO_OFS_SPD_WIDTH: begin
					if (regWrData <= SSO_SPD_WIDTH_MAX) begin
						nxt_speed_coincidence_width = regWrData[6:0]; // RQ9
					end
				end
				SSO_OFS_POS_WIDTH: begin
					if (regWrData <= SSO_POS_WIDTH_MAX) begin
						nxt_positioning_done_width = regWrData[30:0]; // RQ11
					end
				end
				SSO_OFS_TIMING: nxt_done_output_timing_select = regWrData[1:0];
				SSO_OFS_ALLOC_A: nxt_output_allocation_a = regWrData[15:0];
				SSO_OFS_ALLOC_B: nxt_output_allocation_b = regWrData[15:0];
				SSO_OFS_CTRL: nxt_absEncoder = regWrData[SSO_CTRL_ABS_ENC];
				default: ;
			endcase
		end
	end

	// Read data stand only in the cycle after the read strobe
	always_comb begin
		nxt_rdData = 32'h0000_0000;
		if (regRead) begin
			unique case (regAddr)
				SSO_OFS_ROT_LEVEL: nxt_rdData = {18'h00000, rotation_detect_level_ff};
				SSO_OFS_SPD_WIDTH: nxt_rdData = {25'h0000000, speed_coincidence_width_ff};
				SSO_OFS_POS_WIDTH: nxt_rdData = {1'b0, positioning_done_width_ff};
				SSO_OFS_TIMING: nxt_rdData = {30'h00000000, done_output_timing_select_ff};
				SSO_OFS_ALLOC_A: nxt_rdData = {16'h0000, output_allocation_a_ff};
				SSO_OFS_ALLOC_B: nxt_rdData = {16'h0000, output_allocation_b_ff};
				SSO_OFS_CTRL: nxt_rdData = {31'h00000000, absEncoder_ff};
				SSO_OFS_STATUS: nxt_rdData = statusWord;
				default: nxt_rdData = 32'h0000_0000;
			endcase
		end
	end

	// Register the settings and read data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rotation_detect_level_ff <= SSO_ROT_LEVEL_RST;
			speed_coincidence_width_ff <= SSO_SPD_WIDTH_RST;
			positioning_done_width_ff <= SSO_POS_WIDTH_RST;
			done_output_timing_select_ff <= SSO_TIMING_RST;
			output_allocation_a_ff <= SSO_ALLOC_A_RST;
			output_allocation_b_ff <= SSO_ALLOC_B_RST;
			absEncoder_ff <= 1'b0;
			rdData_ff <= 32'h0000_0000;
		end else begin
			rotation_detect_level_ff <= nxt_rotation_detect_level;
			speed_coincidence_width_ff <= nxt_speed_coincidence_width;
			positioning_done_width_ff <= nxt_positioning_done_width;
			done_output_timing_select_ff <= nxt_done_output_timing_select;
			output_allocation_a_ff <= nxt_output_allocation_a;
			output_allocation_b_ff <= nxt_output_allocation_b;
			absEncoder_ff <= nxt_absEncoder;
			rdData_ff <= nxt_rdData;
		end
	end

	assign regRdData = rdData_ff;

	// ----------------------------------------------------------------
	// Magnitudes of motion quantities
	// ----------------------------------------------------------------
	logic signed [16:0] speedDiff;
	logic [16:0] absSpeed, absSpeedDiff;
	logic [31:0] absPosError;

	// Speeds widened before negation so the most negative value is safe
	always_comb begin
		speedDiff = 17'(refSpeed) - 17'(motorSpeed);
		absSpeed = motorSpeed[15] ? 17'(-17'(motorSpeed)) : 17'(motorSpeed);
		absSpeedDiff = speedDiff[16] ? 17'(-speedDiff) : 17'(speedDiff);
		absPosError = positionError[31] ? 32'(-positionError) : 32'(positionError);
	end

	// ----------------------------------------------------------------
	// Flag state
	// ----------------------------------------------------------------
	logic warn_ff, nxt_warn;
	logic rot_ff, nxt_rot;
	logic rdy_ff, nxt_rdy;
	logic spd_ff, nxt_spd;
	logic done_ff, nxt_done;
	logic encOn_ff, nxt_encOn;
	logic srvOn_ff, nxt_srvOn;
	logic errInWidth;

	// Flag conditions; comparisons only, no feedback to motion control
	always_comb begin
		nxt_warn = warningActive; // RQ1
		// Hold the last value only when speed equals the one level
		nxt_rot = rot_ff;
		if (absSpeed > 17'(rotation_detect_level_ff)) begin
			nxt_rot = 1'b1; // RQ2
		end else if (absSpeed < 17'(rotation_detect_level_ff)) begin
			nxt_rot = 1'b0; // RQ2
		end
		// Encoder power-on latched once received
		nxt_encOn = encOn_ff | encoder_power_on_cmd; // RQ6
		nxt_rdy = mainPowerOn && !hardwired_base_block && !alarmActive
			&& (!absEncoder_ff || encOn_ff); // RQ4
		// Servo-on taken only while ready; dropped when ready falls
		nxt_srvOn = srvOn_ff;
		if (!rdy_ff || servoOffCmd) begin
			nxt_srvOn = 1'b0;
		end else if (servo_on_cmd) begin
			nxt_srvOn = 1'b1; // RQ5
		end
		nxt_spd = speedMode && (absSpeedDiff < 17'(speed_coincidence_width_ff)); // RQ7 RQ8
		errInWidth = absPosError < 32'(positioning_done_width_ff); // RQ10 RQ12
		unique case (sso_timing_e'(done_output_timing_select_ff))
			SSO_TIM_FILT: nxt_done = positionMode && errInWidth
				&& (filteredPositionRef == 32'sh0000_0000); // RQ14
			SSO_TIM_REF: nxt_done = positionMode && errInWidth
				&& (positionRefInput == 32'sh0000_0000); // RQ13
			SSO_TIM_ERR: nxt_done = positionMode && errInWidth; // RQ13
			SSO_TIM_RSVD: nxt_done = positionMode && errInWidth;
		endcase
	end

	// Register the flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warn_ff <= 1'b0;
			rot_ff <= 1'b0;
			rdy_ff <= 1'b0;
			spd_ff <= 1'b0;
			done_ff <= 1'b0;
			encOn_ff <= 1'b0;
			srvOn_ff <= 1'b0;
		end else begin
			warn_ff <= nxt_warn;
			rot_ff <= nxt_rot;
			rdy_ff <= nxt_rdy;
			spd_ff <= nxt_spd;
			done_ff <= nxt_done;
			encOn_ff <= nxt_encOn;
			srvOn_ff <= nxt_srvOn;
		end
	end

	assign warningOut = warn_ff;
	assign rotation_detected_out = rot_ff;
	assign servoReadyOut = rdy_ff;
	assign speed_coincidence_out = spd_ff;
	assign positioning_done_out = done_ff;
	assign servoOnOut = srvOn_ff;

	// Status word for software
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[SSO_ST_WARN] = warn_ff;
		statusWord[SSO_ST_ROT] = rot_ff;
		statusWord[SSO_ST_RDY] = rdy_ff;
		statusWord[SSO_ST_SPD] = spd_ff;
		statusWord[SSO_ST_DONE] = done_ff;
		statusWord[SSO_ST_SRV_ON] = srvOn_ff;
		statusWord[SSO_ST_ENC_ON] = encOn_ff;
	end

	// ----------------------------------------------------------------
	// Output allocation
	// ----------------------------------------------------------------
	logic [3:0] digDone, digSpd, digRot, digRdy, digWarn;
	logic [NUM_OUT-1:0] pin_ff, nxt_pin;

	assign digDone = output_allocation_a_ff[SSO_DIG_DONE +: 4];
	assign digSpd = output_allocation_a_ff[SSO_DIG_SPD +: 4];
	assign digRot = output_allocation_a_ff[SSO_DIG_ROT +: 4];
	assign digRdy = output_allocation_a_ff[SSO_DIG_RDY +: 4];
	assign digWarn = output_allocation_b_ff[SSO_DIG_WARN +: 4];

	// Digit n drives pin n-1; digit 0 leaves a flag unassigned
	genvar gp;
	generate
		for (gp = 0; gp < NUM_OUT; gp++) begin : g_pin
			localparam logic [3:0] PIN_CODE = 4'(gp + 1);
			always_comb begin
				nxt_pin[gp] = (done_ff && digDone == PIN_CODE)
					|| (spd_ff && digSpd == PIN_CODE)
					|| (rot_ff && digRot == PIN_CODE)
					|| (rdy_ff && digRdy == PIN_CODE)
					|| (warn_ff && digWarn == PIN_CODE); // RQ15
			end
		end
	endgenerate

	// Register the physical outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_ff <= '0;
		end else begin
			pin_ff <= nxt_pin;
		end
	end

	assign statusPinOut = pin_ff;

endmodule // sso_status_outputs
`default_nettype wire

// file: rtl/sso_pkg.sv
// Purpose: Shared constants for the servo status output block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes: Threshold ranges and reset values live here only
package sso_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SSO_OFS_ROT_LEVEL = 8'h00;
	localparam logic [7:0] SSO_OFS_SPD_WIDTH = 8'h04;
	localparam logic [7:0] SSO_OFS_POS_WIDTH = 8'h08;
	localparam logic [7:0] SSO_OFS_TIMING = 8'h0c;
	localparam logic [7:0] SSO_OFS_ALLOC_A = 8'h10;
	localparam logic [7:0] SSO_OFS_ALLOC_B = 8'h14;
	localparam logic [7:0] SSO_OFS_CTRL = 8'h18;
	localparam logic [7:0] SSO_OFS_STATUS = 8'h1c;

	// ----------------------------------------------------------------
	// Threshold ranges and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] SSO_ROT_LEVEL_MIN = 32'h0000_0001;
	localparam logic [31:0] SSO_ROT_LEVEL_MAX = 32'h0000_2710;
	localparam logic [13:0] SSO_ROT_LEVEL_RST = 14'h0014;
	localparam logic [31:0] SSO_SPD_WIDTH_MAX = 32'h0000_0064;
	localparam logic [6:0] SSO_SPD_WIDTH_RST = 7'h0a;
	localparam logic [31:0] SSO_POS_WIDTH_MAX = 32'h4000_0000;
	localparam logic [30:0] SSO_POS_WIDTH_RST = 31'h0000_0007;
	localparam logic [1:0] SSO_TIMING_RST = 2'h0;
	localparam logic [15:0] SSO_ALLOC_A_RST = 16'h0000;
	localparam logic [15:0] SSO_ALLOC_B_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Allocation digit positions
	// ----------------------------------------------------------------
	localparam int SSO_DIG_DONE = 0;
	localparam int SSO_DIG_SPD = 4;
	localparam int SSO_DIG_ROT = 8;
	localparam int SSO_DIG_RDY = 12;
	localparam int SSO_DIG_WARN = 12;

	// ----------------------------------------------------------------
	// Control and status bit positions
	// ----------------------------------------------------------------
	localparam int SSO_CTRL_ABS_ENC = 0;
	localparam int SSO_ST_WARN = 0;
	localparam int SSO_ST_ROT = 1;
	localparam int SSO_ST_RDY = 2;
	localparam int SSO_ST_SPD = 3;
	localparam int SSO_ST_DONE = 4;
	localparam int SSO_ST_SRV_ON = 5;
	localparam int SSO_ST_ENC_ON = 6;

	// Completion timing modes
	typedef enum logic [1:0] {
		SSO_TIM_ERR = 2'b00,
		SSO_TIM_FILT = 2'b01,
		SSO_TIM_REF = 2'b10,
		SSO_TIM_RSVD = 2'b11
	} sso_timing_e;

endpackage

// file: rtl/sso_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs come from pins outside the clock domain
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sso_pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Raw and filtered levels
	input wire logic [WIDTH-1:0] pinRaw,
	output logic [WIDTH-1:0] pinClean
);

	logic [WIDTH-1:0] stage1_ff, stage2_ff, stage3_ff, clean_ff;
	logic [WIDTH-1:0] nxt_clean;

	// Per-bit agreement filter
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_comb begin
				nxt_clean[gi] = (stage2_ff[gi] == stage3_ff[gi]) ? stage3_ff[gi] : clean_ff[gi];
			end
		end
	endgenerate

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
			clean_ff <= '0;
		end else begin
			stage1_ff <= pinRaw;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
			clean_ff <= nxt_clean;
		end
	end

	assign pinClean = clean_ff;

endmodule // sso_pin_sync
`default_nettype wire

// file: sim/sso_status_outputs_props.sv
// Purpose: Port checks for the status flag block
// Assumes: One clock, bound to the top module
// Notes: Each check ties a flag to its input cause
`timescale 1ns/1ps
`default_nettype none
module sso_status_outputs_props #(
	parameter int NUM_OUT = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Inputs watched
	input wire logic mainPowerPin,
	input wire logic warningActive,
	input wire logic alarmActive,
	input wire logic speedMode,
	input wire logic positionMode,
	input wire logic signed [15:0] motorSpeed,
	input wire logic servo_on_cmd,
	// Outputs watched
	input wire logic warningOut,
	input wire logic rotation_detected_out,
	input wire logic servoReadyOut,
	input wire logic speed_coincidence_out,
	input wire logic positioning_done_out,
	input wire logic servoOnOut,
	input wire logic [NUM_OUT-1:0] statusPinOut
);
	// ----------------------------------------------------------------
	// Flag checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_warn_follow: assert property (1'b1 |=> warningOut == $past(warningActive))
		else $error("warning flag off its cause");
	a_rot_still: assert property (motorSpeed == 16'sh0 |=> !rotation_detected_out)
		else $error("rotation flag at standstill");
	a_rdy_alarm: assert property (alarmActive |=> !servoReadyOut)
		else $error("ready during alarm");
	a_rdy_power: assert property ((!mainPowerPin) [*6] |-> !servoReadyOut)
		else $error("ready without power");
	a_on_accept: assert property ($rose(servoOnOut) |-> $past(servo_on_cmd && servoReadyOut))
		else $error("servo on without ready");
	a_on_drop: assert property (!servoReadyOut |=> !servoOnOut)
		else $error("servo on kept while not ready");
	a_spd_mode: assert property (!speedMode |=> !speed_coincidence_out)
		else $error("coincidence outside speed mode");
	a_done_mode: assert property (!positionMode |=> !positioning_done_out)
		else $error("done outside position mode");
endmodule // sso_status_outputs_props
`default_nettype wire

// file: sim/sso_host_model.sv
// Purpose: Host controller model for encoder-on and servo-on
// Assumes: Drive clock, one-cycle command pulses
// Notes: earlyOn sends servo-on regardless of ready
`timescale 1ns/1ps
`default_nettype none
module sso_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bench control and drive status
	input wire logic goReq,
	input wire logic earlyOn,
	input wire logic [3:0] waitLen,
	input wire logic servoReadyOut,
	// Commands to the drive
	output logic encoder_power_on_cmd,
	output logic servo_on_cmd
);
	logic [1:0] phase_ff;
	logic [3:0] left_ff;
	// Absolute data first, then encoder-on, then servo-on once ready
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_ff <= 2'h0;
			encoder_power_on_cmd <= 1'b0;
			servo_on_cmd <= 1'b0;
		end else begin
			// Each command written once per edge
			encoder_power_on_cmd <= phase_ff == 2'h1 && left_ff == 4'h0;
			servo_on_cmd <= earlyOn || (phase_ff == 2'h2 && servoReadyOut);
			if (phase_ff == 2'h0 && goReq) begin
				phase_ff <= 2'h1;
				left_ff <= waitLen;
			end else if (phase_ff == 2'h1) begin
				left_ff <= left_ff - 4'h1;
				if (left_ff == 4'h0) begin
					phase_ff <= 2'h2;
				end
			end else if (phase_ff == 2'h2 && servoReadyOut) begin
				phase_ff <= 2'h0;
			end
		end
	end
endmodule // sso_host_model
`default_nettype wire

// file: sim/sso_status_outputs_tb.sv
// Purpose: Self-checking bench for the servo status block
// Assumes: 50 MHz clock, host model sends encoder-on and servo-on
// Notes: A cycle model predicts every flag, pin and read word
`timescale 1ns/1ps
`default_nettype none
module sso_status_outputs_tb;
	import sso_pkg::*;
	logic clk, rst_b, regWrite, regRead, mainPowerPin, baseBlockPin, warningActive;
	logic alarmActive, speedMode, positionMode, servoOffCmd, goReq, earlyOn;
	logic encoder_power_on_cmd, servo_on_cmd, warningOut, rotation_detected_out;
	logic servoReadyOut, speed_coincidence_out, positioning_done_out, servoOnOut;
	logic encLat, eW, eR, eRdy, eS, eD, eOn, rdP;
	logic [1:0] s1, s2, s3, cln;
	logic [2:0] statusPinOut, eP;
	logic [3:0] waitLen;
	logic [7:0] regAddr;
	logic [15:0] alcA, alcB;
	logic [31:0] regWrData, regRdData, rnd, eRd;
	logic signed [15:0] motorSpeed, refSpeed;
	logic signed [31:0] positionError, positionRefInput, filteredPositionRef;
	int error_cnt, checked, cycles, lvl, spdW, posW, tim, absEnc;
	logic [39:0] tbl [13] = '{40'h00_00000000, 40'h00_00002711, 40'h00_00000001,
		40'h00_00002710, 40'h04_00000065, 40'h04_00000000, 40'h04_00000064, 40'h08_40000001,
		40'h08_40000000, 40'h08_00000000, 40'h1c_0000ffff, 40'h40_00000005, 40'h0c_00000001};
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic longint mag(input longint v);
		return (v < 0) ? -v : v;
	endfunction
	// ----------------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{s1, s2, s3, cln, encLat, eW, eR, eRdy, eS, eD, eOn, rdP, eP, eRd, alcA, alcB} = '0;
			{lvl, spdW, posW, tim, absEnc} = {32'd20, 32'd10, 32'd7, 32'd0, 32'd0};
		end else begin
			rdP = regRead;
			case (regAddr)
				SSO_OFS_ROT_LEVEL: eRd = lvl;
				SSO_OFS_SPD_WIDTH: eRd = spdW;
				SSO_OFS_POS_WIDTH: eRd = posW;
				SSO_OFS_TIMING: eRd = tim;
				SSO_OFS_ALLOC_A: eRd = 32'(alcA);
				SSO_OFS_ALLOC_B: eRd = 32'(alcB);
				SSO_OFS_CTRL: eRd = absEnc;
				SSO_OFS_STATUS: eRd = 32'({encLat, eOn, eD, eS, eRdy, eR, eW});
				default: eRd = 32'h0;
			endcase
			for (int n = 1; n <= 3; n++) begin
				eP[n-1] = (alcA[3:0] == n) & eD | (alcA[7:4] == n) & eS | (alcA[11:8] == n) & eR
					| (alcA[15:12] == n) & eRdy | (alcB[15:12] == n) & eW;
			end
			eOn = !servoOffCmd && eRdy && (eOn || servo_on_cmd);
			eRdy = cln[0] && !cln[1] && !alarmActive && (absEnc == 0 || encLat);
			encLat = encLat | encoder_power_on_cmd;
			for (int b = 0; b < 2; b++) if (s2[b] == s3[b]) cln[b] = s3[b];
			{s3, s2, s1} = {s2, s1, baseBlockPin, mainPowerPin};
			eW = warningActive;
			if (mag(motorSpeed) != lvl) eR = mag(motorSpeed) > lvl;
			eS = speedMode && mag(longint'(refSpeed) - motorSpeed) < spdW;
			eD = positionMode && mag(positionError) < posW && (tim == 1 ? filteredPositionRef == 0
				: tim == 2 ? positionRefInput == 0 : 1'b1);
			if (regWrite) begin
				case (regAddr)
					SSO_OFS_ROT_LEVEL: if (regWrData >= 1 && regWrData <= 10000) lvl = regWrData;
					SSO_OFS_SPD_WIDTH: if (regWrData <= 100) spdW = regWrData;
					SSO_OFS_POS_WIDTH: if (regWrData <= 32'h4000_0000) posW = regWrData;
					SSO_OFS_TIMING: tim = regWrData[1:0];
					SSO_OFS_ALLOC_A: alcA = regWrData[15:0];
					SSO_OFS_ALLOC_B: alcB = regWrData[15:0];
					SSO_OFS_CTRL: absEnc = regWrData[0];
					default: ;
				endcase
			end
		end
	end
	// Compare between edges
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	always @(negedge clk) begin
		if (rst_b) begin
			chk(32'(warningOut), 32'(eW));
			chk(32'(rotation_detected_out), 32'(eR));
			chk(32'(servoReadyOut), 32'(eRdy));
			chk(32'(servoOnOut), 32'(eOn));
			chk(32'(speed_coincidence_out), 32'(eS));
			chk(32'(positioning_done_out), 32'(eD));
			chk(32'(statusPinOut), 32'(eP));
			chk(regRdData, rdP ? eRd : 32'h0);
		end
	end
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	task automatic bus(input logic [1:0] wr, input logic [39:0] ad);
		@(posedge clk);
		{regWrite, regRead, regAddr, regWrData} <= {wr, ad};
	endtask
	task automatic step;
		@(posedge clk);
		repeat (8) rnd = lfsr(rnd);
		motorSpeed <= 16'(int'(rnd[5:0]) - 32);
		refSpeed <= 16'(int'(rnd[11:6]) - 32);
		positionError <= 32'(int'(rnd[15:12]) - 8);
		positionRefInput <= 32'(rnd[16]);
		filteredPositionRef <= 32'(rnd[17]);
		{speedMode, positionMode, warningActive} <= rnd[20:18];
		alarmActive <= rnd[27:22] == 6'h0;
		servoOffCmd <= rnd[28:22] == 7'h5;
		goReq <= rnd[25:19] == 7'h9;
		earlyOn <= rnd[25:19] == 7'h1a;
		waitLen <= rnd[3:0];
		if (rnd[27:19] == 9'h1f) baseBlockPin <= !baseBlockPin;
		regWrite <= rnd[31:29] == 3'h0;
		regRead <= rnd[31:29] == 3'h1;
		regAddr <= {rnd[10] & rnd[11], 2'h0, rnd[9:7], 2'h0};
		regWrData <= rnd[12] ? 32'(rnd[6:0]) : rnd;
	endtask
	task automatic give_verdict;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 10000) begin
			error_cnt++;
			$display("[FAIL] %0t run did not finish", $time);
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		{regWrite, regRead, mainPowerPin, baseBlockPin, warningActive, alarmActive} = '0;
		{speedMode, positionMode, servoOffCmd, goReq, earlyOn, waitLen, regAddr} = '0;
		{regWrData, motorSpeed, refSpeed, positionError, positionRefInput} = '0;
		{filteredPositionRef, error_cnt, checked, cycles} = '0;
		rnd = 32'h7092;
		rst_b = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 36; a += 4) bus(2'b01, {8'(a), 32'h0});
		foreach (tbl[i]) begin
			bus(2'b10, tbl[i]);
			bus(2'b01, tbl[i]);
		end
		bus(2'b10, {SSO_OFS_CTRL, 32'h1});
		bus(2'b00, 40'h0);
		mainPowerPin <= 1'b1;
		repeat (8) @(posedge clk);
		earlyOn <= 1'b1;
		@(posedge clk);
		{earlyOn, goReq, waitLen} <= 6'h16;
		@(posedge clk);
		goReq <= 1'b0;
		repeat (30) @(posedge clk);
		{servoOffCmd, mainPowerPin} <= 2'b10;
		@(posedge clk);
		servoOffCmd <= 1'b0;
		repeat (10) @(posedge clk);
		mainPowerPin <= 1'b1;
		repeat (4000) step();
		give_verdict();
	end
	sso_host_model host (.clk, .rst_b, .goReq, .earlyOn, .waitLen, .servoReadyOut,
		.encoder_power_on_cmd, .servo_on_cmd);
	sso_status_outputs #(.NUM_OUT(3)) dut (.clk, .rst_b, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData, .mainPowerPin, .baseBlockPin, .warningActive, .alarmActive,
		.speedMode, .positionMode, .motorSpeed, .refSpeed, .positionError, .positionRefInput,
		.filteredPositionRef, .encoder_power_on_cmd, .servo_on_cmd, .servoOffCmd, .warningOut,
		.rotation_detected_out, .servoReadyOut, .speed_coincidence_out, .positioning_done_out,
		.servoOnOut, .statusPinOut);
endmodule // sso_status_outputs_tb
bind sso_status_outputs sso_status_outputs_props #(.NUM_OUT(NUM_OUT)) u_props (.clk, .rst_b,
	.mainPowerPin, .warningActive, .alarmActive, .speedMode, .positionMode, .motorSpeed,
	.servo_on_cmd, .warningOut, .rotation_detected_out, .servoReadyOut, .speed_coincidence_out,
	.positioning_done_out, .servoOnOut, .statusPinOut);
`default_nettype wire
